// ---- did_decode.sv ----
// Purpose: Decode instruction fields, choose multiply signedness and
//          normalize the two accumulators.
// Assumes: Inputs are synchronous to core_clk; fetch holds a word for
//          one cycle with insnValid high.
// Notes:   All outputs are registered; decode results appear one cycle
//          after insnValid.
//
// Contract
// - Accumulator select bit: 0 picks first, 1 picks second.
// - Byte mode bit: 0 word operation, 1 byte operation.
// - Four-bit bit position: 0000 is LSB, 1111 is MSB.
// - Destination bit: 0 default working register, 1 file register.
// - Destination, source and base selects map 0000..1111 to W0..W15.
// - Short file address is 13 bits, reaching 0x0000 to 0x1fff.
// - Word file address is 15 bits with an implied zero LSB.
// - Literals of 1, 4, 6, 8, 10, 14 and 16 bits are supported.
// - Absolute call and jump carry a 23-bit address, LSB zero.
// - Relative branch and call add a 16-bit offset to the PC.
// - Bit test destination: 0 carry flag, 1 zero flag.
// - Double-word bit: 0 word, 1 double-word operation.
// - DSP-only fields decode only in the DSP core variant.
// - Mixed-sign multiply is on when the sign mode field is 10.
// - In mixed mode W4 and W6 are unsigned, W5 and W7 signed.
// - Mixed mode picks product type from operand registers alone.
// - Integer multiply may target either accumulator.
// - Normalize shifts to the largest fraction, sign kept.
// - Normalize writes the applied shift amount out.
// - Negative flag shows the normalize shift direction.
// - An accumulator that cannot be normalized is left unchanged.
// - Each accumulator is 40 bits with eight guard bits.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module did_decode
#(
  parameter bit DSP_VARIANT = 1'b1
)
(
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          insnValid,
  input  wire logic [did_pkg::INSN_W-1:0]    insnWord,
  input  wire logic [did_pkg::INSN_W-1:0]    insnExtWord,
  input  wire did_pkg::did_lit_t             litSel,
  input  wire logic [did_pkg::PADDR_W-1:0]   pcIn,
  input  wire logic                          accLoad,
  input  wire logic                          accLoadSel,
  input  wire logic [did_pkg::ACC_W-1:0]     accLoadData,
  input  wire logic                          normStart,
  input  wire logic [did_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [did_pkg::REG_DATA_W-1:0] regWdata,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output logic [did_pkg::REG_DATA_W-1:0]     regRdata,
  output logic                               decValid,
  output logic                               accSecond,
  output logic                               byteOp,
  output logic                               dwordOp,
  output logic [3:0]                         bitPos,
  output logic [15:0]                        bitMask,
  output logic                               toFileReg,
  output logic                               testToZero,
  output logic [3:0]                         dstReg,
  output logic [3:0]                         srcReg,
  output logic [3:0]                         baseReg,
  output logic [did_pkg::FILE_W-1:0]         fileAddr,
  output logic [did_pkg::OFFS_W-1:0]         fileByteAddr,
  output logic [did_pkg::LIT_MAX_W-1:0]      literal,
  output logic [did_pkg::PADDR_W-1:0]        absTarget,
  output logic [did_pkg::PADDR_W-1:0]        relTarget,
  output logic                               dspFieldsValid,
  output logic [1:0]                         writeBackMode,
  output logic [3:0]                         prefetchOp,
  output logic [1:0]                         prefetchDst,
  output logic [3:0]                         mulOpA,
  output logic [3:0]                         mulOpB,
  output logic                               mulPairInvalid,
  output did_pkg::did_prod_t                 prodType,
  output logic                               intMulToAcc,
  output logic                               intMulAccSecond,
  output logic [did_pkg::ACC_W-1:0]          accFirst,
  output logic [did_pkg::ACC_W-1:0]          accSecondVal,
  output logic                               normDone,
  output logic [5:0]                         normShift,
  output logic                               negFlag
);
  import did_pkg::*;

  // ****************
  // Helper functions
  // ****************

  // Mask that keeps only the literal bits of the chosen width.
  function automatic logic [LIT_MAX_W-1:0] litMask(input did_lit_t sel);
    begin
      case (sel)
        LIT_1:   litMask = 16'h0001;
        LIT_4:   litMask = 16'h000f;
        LIT_6:   litMask = 16'h003f;
        LIT_8:   litMask = 16'h00ff;
        LIT_10:  litMask = 16'h03ff;
        LIT_14:  litMask = 16'h3fff;
        default: litMask = 16'hffff;
      endcase
    end
  endfunction

  // Operand register pair for a multiply with two different registers.
  function automatic logic [8:0] mulPair(input logic [2:0] code);
    begin
      case (code)
        3'h0:    mulPair = {1'b0, 4'h4, 4'h5};
        3'h1:    mulPair = {1'b0, 4'h4, 4'h6};
        3'h2:    mulPair = {1'b0, 4'h4, 4'h7};
        3'h4:    mulPair = {1'b0, 4'h5, 4'h6};
        3'h5:    mulPair = {1'b0, 4'h5, 4'h7};
        3'h6:    mulPair = {1'b0, 4'h6, 4'h7};
        default: mulPair = {1'b1, 4'h4, 4'h5};
      endcase
    end
  endfunction

  // Operand is unsigned in mixed mode when it comes from W4 or W6.
  function automatic logic mixedUnsigned(input logic [3:0] default_working_register);
    begin
      mixedUnsigned = (default_working_register == 4'h4) || (default_working_register == 4'h6);
    end
  endfunction

  // Count of bits below the top that repeat the accumulator sign.
  function automatic logic [5:0] signRun(input logic [ACC_W-1:0] v);
    logic stop;
    begin
      signRun = 6'h00;
      stop = 1'b0;
      for (int i = ACC_W - 2; i >= 0; i--)
      begin
        if (!stop && (v[i] == v[ACC_W-1]))
          signRun = 6'(signRun + 6'h01);
        else
          stop = 1'b1;
      end
    end
  endfunction

  // ****************
  // Combinational decode of the incoming word
  // ****************

  logic [8:0]            pairNext;
  logic [1:0]            signMode;
  logic [15:0]           coreCtl_reg;
  logic                  opAUnsigned;
  logic                  opBUnsigned;
  did_prod_t             prodNext;
  logic [3:0]            imulCode;
  logic [PADDR_W-1:0]    offsExt;

  assign pairNext = mulPair(insnWord[POS_MUL_LO +: 3]);
  assign signMode = coreCtl_reg[POS_SIGN_LO +: 2];
  assign imulCode = insnWord[POS_IMUL_LO +: 4];
  // Offset is sign extended to the program counter width.
  assign offsExt  = {{(PADDR_W-OFFS_W){insnExtWord[OFFS_W-1]}},
                     insnExtWord[OFFS_W-1:0]};

  // Operand signedness follows the sign mode field, or the registers.
  always_comb
  begin
    if (signMode == SIGN_MIXED)
    begin
      opAUnsigned = mixedUnsigned(pairNext[7:4]);
      opBUnsigned = mixedUnsigned(pairNext[3:0]);
    end
    else
    begin
      opAUnsigned = (signMode == SIGN_UNSIGN);
      opBUnsigned = (signMode == SIGN_UNSIGN);
    end
    // Product type comes from operand signedness only.
    case ({opAUnsigned, opBUnsigned})
      2'b00:   prodNext = PROD_SS;
      2'b11:   prodNext = PROD_UU;
      2'b01:   prodNext = PROD_SU;
      default: prodNext = PROD_US;
    endcase
  end

  // ****************
  // Registered decode outputs
  // ****************

  // Pulse marking that the decode outputs hold a fresh word.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      decValid <= 1'b0;
    else
      decValid <= insnValid;
  end

  // General field decode, captured on each valid word.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      byteOp       <= 1'b0;
      dwordOp      <= 1'b0;
      bitPos       <= 4'h0;
      bitMask      <= 16'h0000;
      toFileReg    <= 1'b0;
      testToZero   <= 1'b0;
      dstReg       <= 4'h0;
      srcReg       <= 4'h0;
      baseReg      <= 4'h0;
      fileAddr     <= '0;
      fileByteAddr <= '0;
      literal      <= '0;
      absTarget    <= '0;
      relTarget    <= '0;
    end
    else if (insnValid)
    begin
      byteOp       <= insnWord[POS_BYTE];
      dwordOp      <= insnWord[POS_DWORD];
      bitPos       <= insnWord[POS_BIT_LO +: 4];
      bitMask      <= 16'h0001 << insnWord[POS_BIT_LO +: 4];
      toFileReg    <= insnWord[POS_DEST_BIT];
      testToZero   <= insnWord[POS_DEST_BIT];
      dstReg       <= insnWord[POS_DST_LO +: 4];
      srcReg       <= insnWord[POS_SRC_LO +: 4];
      baseReg      <= insnWord[POS_BASE_LO +: 4];
      fileAddr     <= insnWord[POS_FILE_LO +: FILE_W];
      fileByteAddr <= {insnWord[POS_WADDR_LO +: WADDR_W],
                       1'b0};
      literal      <= insnWord[POS_LIT_LO +: LIT_MAX_W]
                      & litMask(litSel);
      absTarget    <= {insnExtWord[POS_PHI_LO +: PHI_W],
                       insnWord[POS_PLO_LO +: PLO_W],
                       1'b0};
      relTarget    <= PADDR_W'(pcIn + offsExt);
    end
  end

  // DSP-only fields; forced to zero on a core without the DSP engine.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dspFieldsValid <= 1'b0;
      accSecond      <= 1'b0;
      writeBackMode  <= 2'h0;
      prefetchOp     <= 4'h0;
      prefetchDst    <= 2'h0;
    end
    else if (insnValid)
    begin
      dspFieldsValid <= DSP_VARIANT;
      accSecond      <= DSP_VARIANT
                        & insnWord[POS_ACC_SEL];
      writeBackMode  <= DSP_VARIANT ? insnWord[POS_WB_LO +: 2]
                                    : 2'h0;
      prefetchOp     <= DSP_VARIANT ? insnWord[POS_PFX_LO +: 4]
                                    : 4'h0;
      prefetchDst    <= DSP_VARIANT ? insnWord[POS_PFXD_LO +: 2]
                                    : 2'h0;
    end
  end

  // Multiplier operand and destination decode.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mulOpA          <= 4'h4;
      mulOpB          <= 4'h5;
      mulPairInvalid  <= 1'b0;
      prodType        <= PROD_SS;
      intMulToAcc     <= 1'b0;
      intMulAccSecond <= 1'b0;
    end
    else if (insnValid)
    begin
      mulOpA          <= pairNext[7:4];
      mulOpB          <= pairNext[3:0];
      mulPairInvalid  <= pairNext[8];
      prodType        <= prodNext;
      intMulToAcc     <= (imulCode == IMUL_ACC_A)
                         || (imulCode == IMUL_ACC_B);
      intMulAccSecond <= (imulCode == IMUL_ACC_B);
    end
  end

  // ****************
  // Accumulators and normalize
  // ****************

  logic                  normTarget;
  logic [ACC_W-1:0]      normSrc;
  logic [5:0]            runLen;
  logic                  canNorm;
  logic                  goLeft;
  logic [5:0]            shiftMag;
  logic [ACC_W-1:0]      normResult;

  // Normalize acts on the accumulator named by the select bit.
  assign normTarget = insnWord[POS_ACC_SEL];
  assign normSrc    = normTarget ? accSecondVal : accFirst;
  assign runLen     = signRun(normSrc);
  assign canNorm    = (runLen != NORMALIZE_INSTRUCTION_NONE);
  assign goLeft     = (runLen > NORMALIZE_INSTRUCTION_TARGET);
  assign shiftMag   = goLeft ? 6'(runLen - NORMALIZE_INSTRUCTION_TARGET)
                             : 6'(NORMALIZE_INSTRUCTION_TARGET - runLen);
  // Arithmetic right shift keeps the sign; left shift stops short of it.
  assign normResult = goLeft ? (normSrc << shiftMag)
                             : ACC_W'($signed(normSrc) >>> shiftMag);

  // Accumulator storage; a datapath load wins over a normalize.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accFirst     <= '0;
      accSecondVal <= '0;
    end
    else if (accLoad)
    begin
      if (accLoadSel)
        accSecondVal <= accLoadData;
      else
        accFirst <= accLoadData;
    end
    else if (normStart && canNorm)
    begin
      if (normTarget)
        accSecondVal <= normResult;
      else
        accFirst <= normResult;
    end
  end

  // Shift count and direction flag; negative count means a left shift.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      normDone  <= 1'b0;
      normShift <= 6'h00;
      negFlag   <= 1'b0;
    end
    else
    begin
      normDone <= normStart && !accLoad;
      if (normStart && !accLoad)
      begin
        if (canNorm)
        begin
          normShift <= goLeft ? 6'(6'h00 - shiftMag)
                              : shiftMag;
          negFlag   <= goLeft;
        end
        else
        begin
          normShift <= 6'h00;
          negFlag   <= 1'b0;
        end
      end
    end
  end

  // ****************
  // Register port
  // ****************

  // Core control register; holds the multiply sign mode field.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      coreCtl_reg <= CORECTL_RST;
    else if (regWrite && (regAddr == ADDR_CORECTL))
      coreCtl_reg <= regWdata;
  end

  // Read data appear in the cycle after the read strobe, else zero.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      regRdata <= '0;
    else if (regRead && (regAddr == ADDR_CORECTL))
      regRdata <= coreCtl_reg;
    else if (regRead && (regAddr == ADDR_STATUS))
      regRdata <= {8'h00, negFlag, 1'b0, normShift};
    else
      regRdata <= '0;
  end

endmodule

// ---- did_decode_sva.sv ----
// Purpose: Port-level checks for the instruction field decoder.
// Assumes: DSP variant; fields appear one cycle after insnValid.
// Notes:   Attached to every decoder instance by the bind below.
`timescale 1ns/1ps
module did_decode_sva
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        insnValid,
  input wire logic [23:0] insnWord,
  input wire logic [23:0] insnExtWord,
  input wire logic        normStart,
  input wire logic        accLoad,
  input wire logic        decValid,
  input wire logic        accSecond,
  input wire logic [3:0]  bitPos,
  input wire logic [15:0] bitMask,
  input wire logic [15:0] fileByteAddr,
  input wire logic [22:0] absTarget,
  input wire logic        normDone,
  input wire logic [5:0]  normShift,
  input wire logic        negFlag
);
  // ****************
  // Properties
  // ****************
  // All checks run on the core clock and sleep during reset.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_single;
    insnValid ##1 !insnValid;
  endsequence
  sequence s_normalize_instruction_req;
    normStart && !accLoad;
  endsequence

  property p_dec_pulse;
    s_single |-> decValid ##1 !decValid;
  endproperty
  a_dec_pulse: assert property (p_dec_pulse)
    else $error("decode valid is not a single pulse");
  property p_acc_sel;
    insnValid |=> accSecond == $past(insnWord[15]);
  endproperty
  a_acc_sel: assert property (p_acc_sel)
    else $error("accumulator select mismatch");
  property p_bit_mask;
    decValid |-> bitMask == (16'h0001 << bitPos);
  endproperty
  a_bit_mask: assert property (p_bit_mask)
    else $error("bit mask does not follow bit position");
  property p_word_addr;
    insnValid |=> fileByteAddr == {$past(insnWord[15:1]), 1'b0};
  endproperty
  a_word_addr: assert property (p_word_addr)
    else $error("word address lacks implied zero");
  property p_abs;
    insnValid |=> absTarget ==
      {$past(insnExtWord[6:0]), $past(insnWord[15:1]), 1'b0};
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute target mismatch");
  property p_normalize_instruction_done;
    s_normalize_instruction_req |=> normDone;
  endproperty
  a_normalize_instruction_done: assert property (p_normalize_instruction_done)
    else $error("normalize did not complete");
  property p_neg_dir;
    normDone |-> negFlag == normShift[5];
  endproperty
  a_neg_dir: assert property (p_neg_dir)
    else $error("negative flag disagrees with shift sign");
  property p_hold;
    !normStart |=> $stable(normShift) && $stable(negFlag);
  endproperty
  a_hold: assert property (p_hold)
    else $error("shift result changed without normalize");
endmodule

bind did_decode did_decode_sva u_did_decode_sva
(
  .core_clk, .nrst, .insnValid, .insnWord, .insnExtWord, .normStart,
  .accLoad, .decValid, .accSecond, .bitPos, .bitMask, .fileByteAddr,
  .absTarget, .normDone, .normShift, .negFlag
);

// ---- did_decode_tb_top.sv ----
// Purpose: Self-checking bench for the instruction field decoder.
// Assumes: Default DSP variant; fetch model drives the word bus.
// Notes:   Table rows for plain decodes, hand tests for the rest.
`timescale 1ns/1ps
module did_decode_tb_top;
  import did_pkg::*;
  typedef struct packed {
    logic [23:0] w;
    logic [23:0] x;
    logic [22:0] pc;
    did_lit_t    lit;
    logic [15:0] eLit;
    logic [22:0] eAbs;
    logic [22:0] eRel;
  } did_row_t;
  typedef struct packed {
    logic        sel;
    logic [39:0] in;
    logic [39:0] out;
    logic [5:0]  sh;
    logic        n;
  } did_normalize_instruction_t;
  localparam did_row_t ROWS [7] = '{
    '{24'h000010, 24'h000000, 23'h000000, LIT_1, 16'h0001, 23'h10, 23'h0},
    '{24'hffffff, 24'h00ffff, 23'h000010, LIT_4, 16'h000f, 23'h7ffffe,
      23'h00000f},
    '{24'h0abcd5, 24'h008000, 23'h010000, LIT_6, 16'h000d, 23'h00bcd4,
      23'h008000},
    '{24'h012345, 24'h000055, 23'h7fff00, LIT_8, 16'h0034, 23'h552344,
      23'h7fff55},
    '{24'h0fffff, 24'h000001, 23'h7fffff, LIT_10, 16'h03ff, 23'h01fffe,
      23'h000000},
    '{24'h07ffff, 24'h000000, 23'h000005, LIT_14, 16'h3fff, 23'h00fffe,
      23'h000005},
    '{24'h0a5a5a, 24'h00fffe, 23'h000100, LIT_16, 16'ha5a5, 23'h7e5a5a,
      23'h0000fe}};
  localparam did_normalize_instruction_t NROWS [6] = '{
    '{1'b0, 40'h0040000000, 40'h0040000000, 6'h00, 1'b0},
    '{1'b1, 40'h0000000001, 40'h0040000000, 6'h22, 1'b1},
    '{1'b0, 40'h7f00000000, 40'h007f000000, 6'h08, 1'b0},
    '{1'b1, 40'hffffffffff, 40'hffffffffff, 6'h00, 1'b0},
    '{1'b0, 40'hffffff8000, 40'hff80000000, 6'h30, 1'b1},
    '{1'b1, 40'h8000000000, 40'hff80000000, 6'h08, 1'b0}};
  localparam logic [31:0] A_TAB = 32'h46554444;
  localparam logic [31:0] B_TAB = 32'h57765765;
  logic core_clk, nrst, issueReq, issueNorm, accLoad, accLoadSel;
  logic regWrite, regRead, insnValid, normStart;
  logic [23:0] issueWord, issueExt, insnWord, insnExtWord, w;
  logic [22:0] issuePc, pcIn, absTarget, relTarget;
  did_lit_t issueLit, litSel;
  logic [39:0] accLoadData, accFirst, accSecondVal;
  logic [3:0] regAddr, bitPos, dstReg, srcReg, baseReg, prefetchOp;
  logic [3:0] mulOpA, mulOpB, a, b;
  logic [15:0] regWdata, regRdata, bitMask, fileByteAddr, literal, rd;
  logic decValid, accSecond, byteOp, dwordOp, toFileReg, testToZero;
  logic dspFieldsValid, mulPairInvalid, intMulToAcc, intMulAccSecond;
  logic normDone, negFlag, ua, ub;
  logic [12:0] fileAddr;
  logic [1:0] writeBackMode, prefetchDst;
  logic [5:0] normShift;
  did_prod_t prodType, ep;
  int miscompares, samplesChecked, cycles;

  did_fetch_model u_did_fetch_model (.core_clk, .nrst, .issueReq,
    .issueNorm, .issueWord, .issueExt, .issuePc, .issueLit, .insnValid,
    .normStart, .insnWord, .insnExtWord, .pcIn, .litSel);
  did_decode u_did_decode (.core_clk, .nrst, .insnValid, .insnWord,
    .insnExtWord, .litSel, .pcIn, .accLoad, .accLoadSel, .accLoadData,
    .normStart, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .decValid, .accSecond, .byteOp, .dwordOp, .bitPos, .bitMask,
    .toFileReg, .testToZero, .dstReg, .srcReg, .baseReg, .fileAddr,
    .fileByteAddr, .literal, .absTarget, .relTarget, .dspFieldsValid,
    .writeBackMode, .prefetchOp, .prefetchDst, .mulOpA, .mulOpB,
    .mulPairInvalid, .prodType, .intMulToAcc, .intMulAccSecond,
    .accFirst, .accSecondVal, .normDone, .normShift, .negFlag);

  // ****************
  // Helpers
  // ****************
  // Counts a comparison and reports a failed one.
  task automatic check(input logic ok, input string msg);
    samplesChecked++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Prints the verdict and stops.
  task automatic finish_test();
    if (miscompares == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Asks the fetch model for one word and waits for its decode.
  task automatic issue(input logic [23:0] w, input logic [23:0] x,
                       input logic [22:0] pc, input did_lit_t l,
                       input logic n);
    @(posedge core_clk);
    issueReq <= 1'b1;
    issueNorm <= n;
    issueWord <= w;
    issueExt <= x;
    issuePc <= pc;
    issueLit <= l;
    @(posedge core_clk);
    issueReq <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  // One register port cycle each way.
  task automatic reg_write(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= ad;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cuts a hung run short.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    {nrst, issueReq, issueNorm, accLoad, accLoadSel, regWrite} = '0;
    {regRead, issueWord, issueExt, issuePc, accLoadData} = '0;
    {regAddr, regWdata, miscompares, samplesChecked, cycles} = '0;
    issueLit = LIT_1;
    repeat (2) @(posedge core_clk);
    check({decValid, accFirst, mulOpA, mulOpB, prodType} ===
          {1'b0, 40'h0, 4'h4, 4'h5, PROD_SS}, "reset values");
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      issue(ROWS[i].w, ROWS[i].x, ROWS[i].pc, ROWS[i].lit, 1'b0);
      w = ROWS[i].w;
      check({decValid, accSecond, byteOp, dwordOp, bitPos,
        toFileReg, testToZero, dstReg, srcReg, baseReg,
        fileAddr, fileByteAddr, literal, absTarget,
        relTarget, writeBackMode, prefetchOp, prefetchDst,
        dspFieldsValid} === {1'b1, w[15:14], w[6], w[15:12],
        w[13], w[13], w[10:7], w[3:0], w[14:11], w[12:0],
        w[15:1], 1'b0, ROWS[i].eLit, ROWS[i].eAbs,
        ROWS[i].eRel, w[17:16], w[21:18], w[23:22],
        1'b1}, "decoded fields");
    end
    // Every sign mode against every operand pair code.
    for (int m = 0; m < 4; m++)
    begin
      reg_write(4'h0, {2'b00, m[1:0], 12'h000});
      reg_read(4'h0, rd);
      check(rd === {2'b00, m[1:0], 12'h000}, "core control readback");
      for (int p = 0; p < 8; p++)
      begin
        issue({2'b00, p[2:0], 19'h0}, 24'h0, 23'h0, LIT_1, 1'b0);
        a = A_TAB[p*4 +: 4];
        b = B_TAB[p*4 +: 4];
        ua = (m == 2) ? (a == 4'h4 || a == 4'h6) : (m == 1);
        ub = (m == 2) ? (b == 4'h4 || b == 4'h6) : (m == 1);
        ep = ua ? (ub ? PROD_UU : PROD_US) : (ub ? PROD_SU : PROD_SS);
        check({mulOpA, mulOpB, mulPairInvalid, prodType} ===
          {a, b, p[1:0] == 3, ep}, "multiply sign");
      end
    end
    reg_write(4'h7, 16'hffff);
    reg_read(4'h0, rd);
    check(rd === 16'h3000, "unmapped write changed control");
    reg_read(4'h7, rd);
    check(rd === 16'h0000, "unmapped read not zero");
    for (int k = 13; k < 16; k++)
    begin
      issue({k[3:0], 20'h0}, 24'h0, 23'h0, LIT_1, 1'b0);
      check({intMulToAcc, intMulAccSecond} === {k >= 14, k == 15},
            "multiply accumulator target");
    end
    // Normalize cases: shifts both ways, limits and the fixed points.
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      accLoad <= 1'b1;
      accLoadSel <= NROWS[i].sel;
      accLoadData <= NROWS[i].in;
      @(posedge core_clk);
      accLoad <= 1'b0;
      issue({8'h00, NROWS[i].sel, 15'h0}, 24'h0, 23'h0, LIT_1, 1'b1);
      check({normDone, NROWS[i].sel ? accSecondVal : accFirst,
        normShift, negFlag} === {1'b1, NROWS[i].out,
        NROWS[i].sh, NROWS[i].n},
        "normalize result");
    end
    reg_read(4'h1, rd);
    check(rd === 16'h0008, "status readback");
    finish_test();
  end
endmodule

// ---- did_fetch_model.sv ----
// Purpose: Fetch stage model that presents instruction words.
// Assumes: One request per call, launched one cycle after issueReq.
// Notes:   Idle words toggle every cycle so stale use shows up.
`timescale 1ns/1ps
module did_fetch_model
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              issueReq,
  input  wire logic              issueNorm,
  input  wire logic [23:0]       issueWord,
  input  wire logic [23:0]       issueExt,
  input  wire logic [22:0]       issuePc,
  input  wire did_pkg::did_lit_t issueLit,
  output logic                   insnValid,
  output logic                   normStart,
  output logic [23:0]            insnWord,
  output logic [23:0]            insnExtWord,
  output logic [22:0]            pcIn,
  output did_pkg::did_lit_t      litSel
);
  import did_pkg::*;
  // ****************
  // Word delivery
  // ****************
  // Launches a word for one cycle, otherwise scrambles the bus.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      insnValid <= 1'b0;
      normStart <= 1'b0;
      insnWord <= 24'h000000;
      insnExtWord <= 24'h000000;
      pcIn <= 23'h000000;
      litSel <= LIT_1;
    end
    else if (issueReq)
    begin
      insnValid <= 1'b1;
      normStart <= issueNorm;
      insnWord <= issueWord;
      insnExtWord <= issueExt;
      pcIn <= issuePc;
      litSel <= issueLit;
    end
    else
    begin
      insnValid <= 1'b0;
      normStart <= 1'b0;
      insnWord <= ~insnWord;
      insnExtWord <= ~insnExtWord;
    end
  end
endmodule

// ---- did_pkg.sv ----
// Purpose: Shared constants and types for the instruction field decoder.
// Assumes: 24-bit instruction words, 16-bit register port data.
// Notes:   Field positions are fixed per field; formats overlap freely.
package did_pkg;

  // Instruction word and field positions.
  localparam int INSN_W       = 24;
  localparam int ACC_W        = 40;
  localparam int ACC_FRAC_W   = 32;
  localparam int GUARD_W      = ACC_W - ACC_FRAC_W;
  localparam int POS_ACC_SEL  = 15;
  localparam int POS_BYTE     = 14;
  localparam int POS_DEST_BIT = 13;
  localparam int POS_DWORD    = 6;
  localparam int POS_BIT_LO   = 12;
  localparam int POS_DST_LO   = 7;
  localparam int POS_SRC_LO   = 0;
  localparam int POS_BASE_LO  = 11;
  localparam int POS_FILE_LO  = 0;
  localparam int FILE_W       = 13;
  localparam int WADDR_W      = 15;
  localparam int POS_WADDR_LO = 1;
  localparam int POS_LIT_LO   = 4;
  localparam int LIT_MAX_W    = 16;
  localparam int PADDR_W      = 23;
  localparam int POS_PHI_LO   = 0;
  localparam int PHI_W        = 7;
  localparam int POS_PLO_LO   = 1;
  localparam int PLO_W        = 15;
  localparam int OFFS_W       = 16;
  localparam int POS_WB_LO    = 16;
  localparam int POS_PFX_LO   = 18;
  localparam int POS_PFXD_LO  = 22;
  localparam int POS_MUL_LO   = 19;
  localparam int POS_IMUL_LO  = 20;

  // Register port map, data width and reset values.
  localparam int          REG_DATA_W   = 16;
  localparam int          REG_ADDR_W   = 4;
  localparam logic [3:0]  ADDR_CORECTL = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h1;
  localparam logic [15:0] CORECTL_RST  = 16'h0000;
  localparam int          POS_SIGN_LO  = 12;
  localparam logic [1:0]  SIGN_SIGNED  = 2'h0;
  localparam logic [1:0]  SIGN_UNSIGN  = 2'h1;
  localparam logic [1:0]  SIGN_MIXED   = 2'h2;

  // Normalize target: redundant sign bits left above the fraction.
  localparam logic [5:0] NORMALIZE_INSTRUCTION_TARGET = 6'h08;
  localparam logic [5:0] NORMALIZE_INSTRUCTION_NONE   = 6'h27;

  // Integer multiply destination codes that name an accumulator.
  localparam logic [3:0] IMUL_ACC_A = 4'he;
  localparam logic [3:0] IMUL_ACC_B = 4'hf;

  // Literal width selector, one code per supported width.
  typedef enum logic [2:0] {
    LIT_1, LIT_4, LIT_6, LIT_8, LIT_10, LIT_14, LIT_16
  } did_lit_t;

  // Product signedness chosen for a multiply.
  typedef enum logic [1:0] {
    PROD_SS, PROD_UU, PROD_SU, PROD_US
  } did_prod_t;

endpackage
